// ==== inc/clk_ctrl_pkg.sv ====
// Constants, field positions and carrier types for the clock source control block.
// Assumes a single 20 MHz reference clock and a plain register port.
package clk_ctrl_pkg;
   // ***************************************************
   // Register addresses (word index on the plain port)
   // ***************************************************
   localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
   localparam logic [1:0] ADDR_CLK_DIV = 2'h1;
   localparam logic [1:0] ADDR_PLL_FBD = 2'h2;
   localparam logic [1:0] ADDR_STATUS = 2'h3;
   // ***************************************************
   // Oscillator control field positions
   // ***************************************************
   localparam int CUR_LSB = 12;
   localparam int REQ_LSB = 8;
   localparam int LOCK_BIT = 7;
   localparam int PINLOCK_BIT = 6;
   localparam int PLLOK_BIT = 5;
   localparam int FAIL_BIT = 3;
   localparam int SECONDARY_CRYSTAL_OSC_BIT = 1;
   localparam int SWREQ_BIT = 0;
   // ***************************************************
   // Clock divisor field positions and reset values
   // ***************************************************
   localparam int RCDIV_LSB = 8;
   localparam int POST_LSB = 6;
   localparam int PRE_LSB = 0;
   localparam logic [15:0] CLK_DIV_RST = 16'h0040;
   localparam logic [8:0] PLL_FBD_RST = 9'h030;
   localparam logic [15:0] CLK_DIV_WMASK = 16'h07DF;
   // ***************************************************
   // Timing: PLL start-up time and derived cycle count
   // ***************************************************
   localparam int CLK_HZ = 20000000;
   localparam int PLL_START_US = 100;
   localparam int PLL_START_CYC = (PLL_START_US * (CLK_HZ / 1000000));
   localparam int SW_SETTLE_CYC = 4;
   // ***************************************************
   // Source codes and submodes
   // ***************************************************
   typedef enum logic [2:0] {
      SRC_FRC = 3'h0, SRC_FRC_PLL = 3'h1, SRC_PRI = 3'h2, SRC_PRI_PLL = 3'h3,
      SRC_SEC = 3'h4, SRC_LOW_POWER_RC_OSC = 3'h5, SRC_FRC_D16 = 3'h6, SRC_FRC_DN = 3'h7
   } src_e;
   localparam logic [2:0] ERASED_SRC = 3'h7;
   localparam logic [1:0] PRI_HS = 2'h2;
   localparam logic [1:0] PRI_XT = 2'h1;
   localparam logic [1:0] PRI_EC = 2'h0;
   // Register port request bundle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] addr;
      logic [15:0] wdata;
   } bus_req_s;
   // Clock path settings handed to the analog side
   typedef struct packed {
      logic [2:0] source;
      logic pll_on;
      logic [1:0] pri_mode;
      logic [8:0] rc_div;
      logic [5:0] pre_div;
      logic [3:0] post_div;
      logic [9:0] fbd_mult;
   } clk_cfg_s;
endpackage

// ==== hw/clk_ctrl.sv ====
// Clock source selection, PLL divider settings and oscillator control register.
// Assumes configuration fields are stable at reset release and that the
// analog oscillators, PLL and fail-safe monitor sit outside this block.
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Register port
   input wire clk_ctrl_pkg::bus_req_s i_bus,
   output logic [15:0] o_rdata,
   // Nonvolatile configuration fields (pins, asynchronous)
   input wire logic [2:0] i_initial_source_config,
   input wire logic [1:0] i_primary_submode_config,
   input wire logic i_switch_monitor_config_bit,
   // Analog side status (asynchronous)
   input wire logic i_pll_locked,
   input wire logic i_clock_fail_det,
   // Settings and status outputs
   output clk_ctrl_pkg::clk_cfg_s o_cfg,
   output logic o_secondary_osc_enable,
   output logic o_pin_map_write_lock,
   output logic o_low_power_rc_ref,
   output logic o_failsafe_monitor_en
);
   // ***************************************************
   // Synchronisers for asynchronous inputs
   // ***************************************************
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [2:0] cfg_src;
   logic [1:0] cfg_pri;
   logic cfg_sw_n;
   logic pll_lock_s;
   logic fail_s;
   // Two stages; only the second stage is read
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= {i_initial_source_config, i_primary_submode_config,
                       i_switch_monitor_config_bit, i_pll_locked, i_clock_fail_det};
         sync2_reg <= sync1_reg;
      end
   end
   assign cfg_src = sync2_reg[7:5];
   assign cfg_pri = sync2_reg[4:3];
   assign cfg_sw_n = sync2_reg[2];
   assign pll_lock_s = sync2_reg[1];
   assign fail_s = sync2_reg[0];

   // ***************************************************
   // Helper functions
   // ***************************************************
   // PLL path only for fast RC and primary sources
   function automatic logic uses_pll(input logic [2:0] s);
      uses_pll = (s == 3'(clk_ctrl_pkg::SRC_FRC_PLL)) ||
                 (s == 3'(clk_ctrl_pkg::SRC_PRI_PLL));
   endfunction
   // Byte-lane style field pick from a write
   function automatic logic [2:0] field3(input logic [15:0] d, input int lsb);
      field3 = d[lsb +: 3];
   endfunction

   // ***************************************************
   // Power-on capture of configuration
   // ***************************************************
   // Straps are caught after release, once synchronised
   logic [1:0] boot_cnt_reg;
   logic booted_reg;
   logic [1:0] pri_mode_reg;
   logic sw_en_reg;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         boot_cnt_reg <= 2'h0;
         booted_reg <= 1'b0;
      end else if (!booted_reg) begin
         boot_cnt_reg <= boot_cnt_reg + 2'h1;
         booted_reg <= (boot_cnt_reg == 2'h2);
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pri_mode_reg <= clk_ctrl_pkg::PRI_EC;
         sw_en_reg <= 1'b0;
      end else if (!booted_reg && boot_cnt_reg == 2'h2) begin
         pri_mode_reg <= cfg_pri;
         sw_en_reg <= ~cfg_sw_n;
      end
   end

   // ***************************************************
   // Oscillator control register
   // ***************************************************
   logic [2:0] cur_src_reg;
   logic [2:0] req_src_reg;
   logic lock_reg;
   logic pinlock_reg;
   logic fail_reg;
   logic secondary_crystal_osc_reg;
   logic swreq_reg;
   logic [2:0] settle_reg;
   logic wr_osc;
   logic lock_allowed;
   assign wr_osc = i_bus.wr && (i_bus.addr == clk_ctrl_pkg::ADDR_OSC_CTRL);
   // Lock applies whenever switching is on; monitor is tied to switch, so it is on too
   assign lock_allowed = sw_en_reg;

   // Source fields: erased default until config captured
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cur_src_reg <= clk_ctrl_pkg::ERASED_SRC;
         req_src_reg <= clk_ctrl_pkg::ERASED_SRC;
      end else if (!booted_reg && boot_cnt_reg == 2'h2) begin
         cur_src_reg <= cfg_src;
         req_src_reg <= cfg_src;
      end else begin
         if (wr_osc) begin
            req_src_reg <= field3(i_bus.wdata, clk_ctrl_pkg::REQ_LSB);
         end
         if (swreq_reg && settle_reg == 3'(clk_ctrl_pkg::SW_SETTLE_CYC)) begin
            cur_src_reg <= req_src_reg;
         end
      end
   end

   // Switch request: self-clears after settle; refused when locked or disabled
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         swreq_reg <= 1'b0;
         settle_reg <= 3'h0;
      end else if (swreq_reg) begin
         settle_reg <= settle_reg + 3'h1;
         if (settle_reg == 3'(clk_ctrl_pkg::SW_SETTLE_CYC)) begin
            swreq_reg <= 1'b0;
            settle_reg <= 3'h0;
         end
      end else if (wr_osc && i_bus.wdata[clk_ctrl_pkg::SWREQ_BIT] && sw_en_reg &&
                   !(lock_allowed && lock_reg)) begin
         swreq_reg <= 1'b1;
      end
   end

   // Plain control bits
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lock_reg <= 1'b0;
         pinlock_reg <= 1'b0;
         secondary_crystal_osc_reg <= 1'b0;
      end else if (wr_osc) begin
         lock_reg <= i_bus.wdata[clk_ctrl_pkg::LOCK_BIT];
         pinlock_reg <= i_bus.wdata[clk_ctrl_pkg::PINLOCK_BIT];
         secondary_crystal_osc_reg <= i_bus.wdata[clk_ctrl_pkg::SECONDARY_CRYSTAL_OSC_BIT];
      end
   end

   // Clock fail flag: set wins over software clear
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fail_reg <= 1'b0;
      end else if (fail_s && sw_en_reg) begin
         fail_reg <= 1'b1;
      end else if (wr_osc && !i_bus.wdata[clk_ctrl_pkg::FAIL_BIT]) begin
         fail_reg <= 1'b0;
      end
   end

   // ***************************************************
   // PLL start-up timer and lock status
   // ***************************************************
   // Timer restarts whenever the PLL path is off
   logic [11:0] pll_tmr_reg;
   logic pll_ok_reg;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pll_tmr_reg <= 12'h000;
         pll_ok_reg <= 1'b0;
      end else if (!uses_pll(cur_src_reg)) begin
         pll_tmr_reg <= 12'h000;
         pll_ok_reg <= 1'b0;
      end else begin
         if (pll_tmr_reg != 12'(clk_ctrl_pkg::PLL_START_CYC)) begin
            pll_tmr_reg <= pll_tmr_reg + 12'h001;
         end
         pll_ok_reg <= pll_lock_s ||
                       (pll_tmr_reg == 12'(clk_ctrl_pkg::PLL_START_CYC));
      end
   end

   // ***************************************************
   // Divisor registers
   // ***************************************************
   logic [15:0] clk_div_reg;
   logic [8:0] pll_fbd_reg;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clk_div_reg <= clk_ctrl_pkg::CLK_DIV_RST;
         pll_fbd_reg <= clk_ctrl_pkg::PLL_FBD_RST;
      end else if (i_bus.wr) begin
         if (i_bus.addr == clk_ctrl_pkg::ADDR_CLK_DIV) begin
            clk_div_reg <= i_bus.wdata & clk_ctrl_pkg::CLK_DIV_WMASK;
         end
         if (i_bus.addr == clk_ctrl_pkg::ADDR_PLL_FBD) begin
            pll_fbd_reg <= i_bus.wdata[8:0];
         end
      end
   end

   // ***************************************************
   // Effective clock path settings
   // ***************************************************
   clk_ctrl_pkg::clk_cfg_s cfg_next;
   logic [2:0] rcd;
   logic [1:0] post;
   always_comb begin
      rcd = clk_div_reg[clk_ctrl_pkg::RCDIV_LSB +: 3];
      post = clk_div_reg[clk_ctrl_pkg::POST_LSB +: 2];
      cfg_next.source = cur_src_reg;
      cfg_next.pll_on = uses_pll(cur_src_reg);
      cfg_next.pri_mode = pri_mode_reg;
      // Divide-by-N code 111 uses the postscaler; 1:1 when code 0
      if (cur_src_reg == 3'(clk_ctrl_pkg::SRC_FRC_D16)) begin
         cfg_next.rc_div = 9'h010;
      end else if (cur_src_reg == 3'(clk_ctrl_pkg::SRC_FRC_DN)) begin
         cfg_next.rc_div = (rcd == 3'h7) ? 9'h100 : (9'h001 << rcd);
      end else begin
         cfg_next.rc_div = 9'h001;
      end
      cfg_next.pre_div = 6'(clk_div_reg[clk_ctrl_pkg::PRE_LSB +: 5]) + 6'h02;
      // Reserved code 10 treated as divide by 4
      cfg_next.post_div = (post == 2'h3) ? 4'h8 : ((post == 2'h0) ? 4'h2 : 4'h4);
      cfg_next.fbd_mult = 10'(pll_fbd_reg) + 10'h002;
   end
   // Registered so the analog side sees no glitches; Fosc/2 for Fcy is implied
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cfg <= '0;
      end else begin
         o_cfg <= cfg_next;
      end
   end

   // ***************************************************
   // Side outputs
   // ***************************************************
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_secondary_osc_enable <= 1'b0;
         o_pin_map_write_lock <= 1'b0;
         o_low_power_rc_ref <= 1'b0;
         o_failsafe_monitor_en <= 1'b0;
      end else begin
         o_secondary_osc_enable <= secondary_crystal_osc_reg || (cur_src_reg == 3'(clk_ctrl_pkg::SRC_SEC));
         o_pin_map_write_lock <= pinlock_reg;
         o_low_power_rc_ref <= 1'b1;
         o_failsafe_monitor_en <= sw_en_reg;
      end
   end

   // ***************************************************
   // Read port, data one cycle after strobe
   // ***************************************************
   logic [15:0] osc_word;
   assign osc_word = {1'b0, cur_src_reg, 1'b0, req_src_reg, lock_reg, pinlock_reg,
                      pll_ok_reg, 1'b0, fail_reg, 1'b0, secondary_crystal_osc_reg, swreq_reg};
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_bus.rd) begin
         unique case (i_bus.addr)
            clk_ctrl_pkg::ADDR_OSC_CTRL: o_rdata <= osc_word;
            clk_ctrl_pkg::ADDR_CLK_DIV: o_rdata <= clk_div_reg;
            clk_ctrl_pkg::ADDR_PLL_FBD: o_rdata <= {7'h00, pll_fbd_reg};
            clk_ctrl_pkg::ADDR_STATUS: o_rdata <= {13'h0000, booted_reg, sw_en_reg,
                                                   pll_lock_s};
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   sequence s_req_taken;
      !swreq_reg ##1 swreq_reg;
   endsequence
   AST_SWITCH_DONE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_req_taken |-> swreq_reg [*5] ##1 !swreq_reg)
      else $error("switch request did not clear in time");
   AST_CUR_FOLLOWS: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      $fell(swreq_reg) |-> cur_src_reg == req_src_reg)
      else $error("current source not updated");
   AST_LOCK_BLOCKS: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      (lock_reg && !swreq_reg) |=> !$rose(swreq_reg))
      else $error("switch started while locked");
   AST_NO_SW: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !sw_en_reg |=> !swreq_reg && !fail_reg)
      else $error("switch or fail with switching disabled");
   AST_FAIL_STICKY: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      (fail_reg && !wr_osc) |=> fail_reg)
      else $error("fail flag dropped without clear");
   AST_PLL_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !uses_pll(cur_src_reg) |=> !pll_ok_reg)
      else $error("pll ok with pll off");
   AST_RD_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_bus.rd && i_bus.addr == clk_ctrl_pkg::ADDR_OSC_CTRL) |=>
      (o_rdata[15] == 1'b0 && o_rdata[11] == 1'b0 && o_rdata[4] == 1'b0 && o_rdata[2] == 1'b0))
      else $error("unimplemented bit read as one");
   AST_PRE_DIV: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      i_arst_n |=> o_cfg.pre_div == 6'($past(clk_div_reg[4:0])) + 6'h02)
      else $error("prescale factor wrong");
   AST_PIN_LOCK: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      1'b1 |=> o_pin_map_write_lock == $past(pinlock_reg))
      else $error("pin map lock output wrong");
endmodule
`default_nettype wire

// ==== bench/clk_src_model.sv ====
// Partner model of the analog clock side: a PLL that locks a while after
// it is enabled, and a fail-safe detector that raises its flag on command.
// Assumes one reference clock; the lock delay parameter gives prompt or slow lock.
`timescale 1ns/1ns
`default_nettype none
module clk_src_model #(
   parameter int LOCK_CYC = 40
) (
   // Clock
   input wire logic i_ref_clk,
   // Control from the block and the bench
   input wire logic i_pll_on,
   input wire logic i_fail_cmd,
   // Status towards the block
   output logic o_pll_locked,
   output logic o_clock_fail_det
);
   int cnt = 0;
   // Loop needs time to settle; disabling it drops lock on the next clock edge
   always @(posedge i_ref_clk) begin
      if (!i_pll_on) cnt <= 0;
      else if (cnt < LOCK_CYC) cnt <= cnt + 1;
   end
   assign o_pll_locked = (cnt >= LOCK_CYC);
   // Detector level follows the bench command
   assign o_clock_fail_det = i_fail_cmd;
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the clock source control block.
// Assumes the package, the design and the partner model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ***************************************************
   // Signals
   // ***************************************************
   logic i_ref_clk, i_arst_n, sw_cfg, lock, fdet, fail_cmd;
   logic secondary_crystal_osc_en, pin_lock, low_power_rc_osc_ref, fsm_en;
   logic [2:0] init_src;
   logic [1:0] submode;
   logic [15:0] o_rdata, d, v, f;
   logic [31:0] seed;
   clk_ctrl_pkg::bus_req_s bus;
   clk_ctrl_pkg::clk_cfg_s cfg;
   int fail_count, checks_done, cycles;
   // ***************************************************
   // Design and partner
   // ***************************************************
   clk_ctrl dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(o_rdata),
      .i_initial_source_config(init_src), .i_primary_submode_config(submode),
      .i_switch_monitor_config_bit(sw_cfg), .i_pll_locked(lock), .i_clock_fail_det(fdet),
      .o_cfg(cfg), .o_secondary_osc_enable(secondary_crystal_osc_en), .o_pin_map_write_lock(pin_lock),
      .o_low_power_rc_ref(low_power_rc_osc_ref), .o_failsafe_monitor_en(fsm_en));
   clk_src_model model (.i_ref_clk(i_ref_clk), .i_pll_on(cfg.pll_on), .i_fail_cmd(fail_cmd),
      .o_pll_locked(lock), .o_clock_fail_det(fdet));
   // Free-running 20 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic [15:0] osc(input logic [2:0] c, input logic [2:0] r,
      input logic [7:0] lo);
      osc = {1'b0, c, 1'b0, r, lo};
   endfunction
   function automatic logic [3:0] post(input logic [1:0] c);
      post = (c == 2'h0) ? 4'h2 : ((c == 2'h3) ? 4'h8 : 4'h4);
   endfunction
   // Fast RC postscale: powers of two, top code jumps to 256
   function automatic logic [8:0] rcdiv(input logic [2:0] c);
      rcdiv = (c == 3'h7) ? 9'h100 : (9'h001 << c);
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] x);
      @(posedge i_ref_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: x};
      @(posedge i_ref_clk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [15:0] x);
      @(posedge i_ref_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge i_ref_clk);
      bus.rd <= 1'b0;
      #1 x = o_rdata;
   endtask
   task automatic pulse_fail();
      @(posedge i_ref_clk);
      fail_cmd <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      fail_cmd <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
   endtask
   task automatic reset_with(input logic [2:0] s, input logic c);
      i_arst_n <= 1'b0;
      init_src <= s;
      sw_cfg <= c;
      repeat (8) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
   endtask
   // Request a switch, wait for completion under a bound, check the result
   task automatic switch_to(input logic [2:0] s);
      int n;
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, {5'h00, s, 8'h01});
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("switch pending", 16'h0001, {15'h0000, d[0]});
      for (n = 0; n < 20 && d[0] !== 1'b0; n++) rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("switched word", osc(s, s, 8'h00), d & 16'hFFDF);
      repeat (3) @(posedge i_ref_clk);
      chk("cfg source", {13'h0000, s}, {13'h0000, cfg.source});
      chk("pll path", {15'h0000, s == 3'h1 || s == 3'h3}, {15'h0000, cfg.pll_on});
      chk("secondary_crystal_osc enable", {15'h0000, s == 3'h4}, {15'h0000, secondary_crystal_osc_en});
      chk("rc path", {7'h00, (s == 3'h6) ? 9'h010 : 9'h001}, {7'h00, cfg.rc_div});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, far above the expected few hundred cycles
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("timeout reached");
         results();
      end
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      i_arst_n = 1'b0;
      bus = '0;
      fail_cmd = 1'b0;
      submode = clk_ctrl_pkg::PRI_XT;
      seed = 32'hfd048637;
      fail_count = 0;
      checks_done = 0;
      cycles = 0;
      reset_with(3'h3, 1'b0);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("osc reset", osc(3'h3, 3'h3, 8'h00), d);
      @(posedge i_ref_clk);
      #1 chk("rdata idle", 16'h0000, o_rdata);
      rd(clk_ctrl_pkg::ADDR_CLK_DIV, d);
      chk("div reset", 16'h0040, d);
      rd(clk_ctrl_pkg::ADDR_PLL_FBD, d);
      chk("fbd reset", 16'h0030, d);
      chk("pri mode", {14'h0000, clk_ctrl_pkg::PRI_XT}, {14'h0000, cfg.pri_mode});
      chk("ref and monitor", 16'h0003, {14'h0000, low_power_rc_osc_ref, fsm_en});
      $display("test reset done");
      repeat (60) @(posedge i_ref_clk);
      wr(clk_ctrl_pkg::ADDR_STATUS, 16'h0000);
      rd(clk_ctrl_pkg::ADDR_STATUS, d);
      chk("status locked", 16'h0007, d);
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'hF8F6);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("unused bits", osc(3'h3, 3'h0, 8'hE2), d);
      chk("pin lock out", 16'h0003, {14'h0000, pin_lock, secondary_crystal_osc_en});
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'h05C1);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("locked refuse", osc(3'h3, 3'h5, 8'hC0), d & 16'hFFDF);
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'h0000);
      $display("test locks done");
      for (int s = 0; s < 8; s++) switch_to(3'(s));
      $display("test switching done");
      // Ends on fast RC divide-by-N, so the RC postscaler is live
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         v = (i == 0) ? 16'h0300 : ((i == 1) ? 16'h07FF : seed[15:0]);
         f = (i == 0) ? 16'h001E : seed[31:16];
         wr(clk_ctrl_pkg::ADDR_CLK_DIV, v);
         wr(clk_ctrl_pkg::ADDR_PLL_FBD, f);
         rd(clk_ctrl_pkg::ADDR_CLK_DIV, d);
         chk("div rb", v & clk_ctrl_pkg::CLK_DIV_WMASK, d);
         rd(clk_ctrl_pkg::ADDR_PLL_FBD, d);
         chk("fbd rb", {7'h00, f[8:0]}, d);
         repeat (2) @(posedge i_ref_clk);
         chk("pre div", {10'h000, 6'(v[4:0]) + 6'h02}, {10'h000, cfg.pre_div});
         chk("post div", {12'h000, post(v[7:6])}, {12'h000, cfg.post_div});
         chk("mult", {6'h00, 10'(f[8:0]) + 10'h002}, {6'h00, cfg.fbd_mult});
         chk("rc div", {7'h00, rcdiv(v[10:8])}, {7'h00, cfg.rc_div});
      end
      $display("test divisors done");
      pulse_fail();
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("fail set", 16'h0008, d & 16'h0008);
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'h0708);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("fail kept", 16'h0008, d & 16'h0008);
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'h0700);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("fail cleared", 16'h0000, d & 16'h0008);
      // Clear written while the detector still reports: the set must win
      @(posedge i_ref_clk);
      fail_cmd <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'h0700);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("fail set wins", 16'h0008, d & 16'h0008);
      @(posedge i_ref_clk);
      fail_cmd <= 1'b0;
      $display("test fail flag done");
      submode <= clk_ctrl_pkg::PRI_HS;
      reset_with(clk_ctrl_pkg::ERASED_SRC, 1'b1);
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("erased source", osc(3'h7, 3'h7, 8'h00), d & 16'hFFDF);
      chk("monitor off", 16'h0000, {15'h0000, fsm_en});
      chk("pri mode hs", {14'h0000, clk_ctrl_pkg::PRI_HS}, {14'h0000, cfg.pri_mode});
      wr(clk_ctrl_pkg::ADDR_OSC_CTRL, 16'h0001);
      pulse_fail();
      rd(clk_ctrl_pkg::ADDR_OSC_CTRL, d);
      chk("switch disabled", osc(3'h7, 3'h0, 8'h00), d & 16'hFFDF);
      $display("test config disable done");
      results();
   end
endmodule
`default_nettype wire
